// ---- hw/tpp_db_if.sv ----
// link between the output stage and one dead-band delay unit
interface tpp_db_if;
  logic       raw;
  logic [2:0] sel;
  logic       dly_out;

  modport src (output raw, output sel, input dly_out);
  modport dly (input raw, input sel, output dly_out);
endinterface : tpp_db_if

// ---- hw/tpp_deadband.sv ----
// rising-edge delay for one pwm output
module tpp_deadband
  import tpp_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // level in, delayed level out
  tpp_db_if.dly     db
);

  typedef struct packed {
    logic [7:0] cnt;
    logic       out;
  } tpp_db_s;

  tpp_db_s     s;
  tpp_db_s     next_s;
  logic [7:0]  len;

  assign len = (db.sel == 3'h0) ? 8'h00 : pow2(db.sel);

  always_comb begin
    next_s = s;
    if (!db.raw) begin
      // falls on the next clock with no dead-band, so the two outputs never overlap
      next_s.out = 1'b0;
      next_s.cnt = 8'h00;
    end else if (!s.out) begin
      if (s.cnt >= len) begin
        next_s.out = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign db.dly_out = s.out;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  fall_undelayed_a: assert property (!db.raw |=> !db.dly_out)
    else $error("dead-band delayed a falling edge");

  rise_delay_a: assert property (
    ($rose(db.raw) && db.sel == 3'h1) ##1 (db.raw && db.sel == 3'h1)[*2]
      |=> db.dly_out && $past(!db.dly_out))
    else $error("dead-band of two cycles not applied");

endmodule : tpp_deadband

// ---- hw/tpp_pkg.sv ----
// constants, field layout and helpers for the timer polarity/prescaler block
//------------------------------------------------------------------------
// Summary of operation
// - Disabled timer holds the output pin at the programmed polarity level.
// - One-shot mode: output changes state for one clock after reload.
// - Listed reload-driven modes toggle the output after every reload.
// - Counter mode counts rising input edges for polarity 0, falling for 1.
// - Single PWM: output forced to one level at match, back at reload.
// - Capture-type modes latch count on the polarity-selected input edge.
// - Gated mode counts on active input level, interrupts on inactive edge.
// - Capture/compare starts on first selected edge, captures on later ones.
// - Dual PWM drives output at match and reload; complement is its inverse.
// - Triggered one-shot starts on the polarity-selected input transition.
// - Prescaler divides the timer input clock by two to the field value.
// - Prescaler counter is cleared whenever the timer is disabled.
// - Dead-band field selects 0 or 2 to 128 extra clocks before assertion.
//------------------------------------------------------------------------
package tpp_pkg;

  //----------------------------------------------------------------------
  // register map (word aligned byte addresses)
  //----------------------------------------------------------------------
  localparam logic [7:0]  OFS_CTL_ONE   = 8'h00;
  localparam logic [7:0]  OFS_CTL_ZERO  = 8'h04;
  localparam logic [7:0]  OFS_STATUS    = 8'h08;
  localparam logic [7:0]  OFS_CLEAR     = 8'h0c;
  localparam logic [7:0]  OFS_IRQ_EN    = 8'h10;

  localparam logic [7:0]  RST_CTL_ONE   = 8'h00;
  localparam logic [3:0]  RST_CTL_ZERO  = 4'h0;

  // timer_control_one fields
  localparam int          BIT_ENABLE    = 7;
  localparam int          BIT_POLARITY  = 6;
  localparam int          CLOCK_PRESCALE_SELECT_MSB      = 5;
  localparam int          CLOCK_PRESCALE_SELECT_LSB      = 3;
  localparam int          MODE_LO_MSB   = 2;
  // control zero fields: [3] mode high bit, [2:0] dead-band select
  localparam int          BIT_MODE_HI   = 3;
  localparam int          DB_MSB        = 2;

  // status / clear / enable bits
  localparam int          ST_RELOAD     = 0;
  localparam int          ST_CAPTURE    = 1;
  localparam int          ST_GATE       = 2;
  localparam int          ST_W          = 3;

  //----------------------------------------------------------------------
  // operating modes
  //----------------------------------------------------------------------
  localparam logic [3:0]  M_ONESHOT     = 4'h0;
  localparam logic [3:0]  M_CONT        = 4'h1;
  localparam logic [3:0]  M_COUNTER     = 4'h2;
  localparam logic [3:0]  M_PWM         = 4'h3;
  localparam logic [3:0]  M_CAPTURE     = 4'h4;
  localparam logic [3:0]  M_COMPARE     = 4'h5;
  localparam logic [3:0]  M_GATED       = 4'h6;
  localparam logic [3:0]  M_CAPCMP      = 4'h7;
  localparam logic [3:0]  M_DUALPWM     = 4'h8;
  localparam logic [3:0]  M_CAPRST      = 4'h9;
  localparam logic [3:0]  M_CMPCNT      = 4'ha;
  localparam logic [3:0]  M_TRIG        = 4'hb;

  // 2 to the power of a 3-bit select: prescale ratio and dead-band length
  function automatic logic [7:0] pow2(input logic [2:0] sel);
    pow2 = 8'h01 << sel;
  endfunction : pow2

  function automatic logic toggles(input logic [3:0] m);
    toggles = (m == M_CONT)   || (m == M_COUNTER) || (m == M_CAPTURE) ||
              (m == M_COMPARE) || (m == M_GATED)  || (m == M_CAPCMP)  ||
              (m == M_CAPRST) || (m == M_CMPCNT)  || (m == M_TRIG);
  endfunction : toggles

  function automatic logic captures(input logic [3:0] m);
    captures = (m == M_CAPTURE) || (m == M_CAPRST) || (m == M_CMPCNT);
  endfunction : captures

endpackage : tpp_pkg

// ---- hw/tpp_top.sv ----
// timer polarity, prescaler and output stage with apb registers
//
// Implementation choices: the register addresses and the APB interface to the registers.
module tpp_top
  import tpp_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // counter core events
  input  wire logic        reload_i,
  input  wire logic        match_i,
  // timer pins
  input  wire logic        tin_i,
  output logic             tout_o,
  output logic             tout_n_o,
  // to counter core
  output logic             enable_o,
  output logic [3:0]       mode_o,
  output logic             count_tick_o,
  output logic             capture_o,
  output logic             start_o,
  // interrupt
  output logic             irq_o
);

  //----------------------------------------------------------------------
  // state
  //----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]      ctl1;
    logic [3:0]      ctl0;
    logic [ST_W-1:0] stat;
    logic [ST_W-1:0] ien;
    logic            lvl;
    logic [6:0]      pcnt;
    logic            tin_q;
    logic            armed;
    logic            tick;
    logic            cap;
    logic            start;
    logic [31:0]     rdata;
    logic            err;
  } tpp_st_s;

  tpp_st_s         s;
  tpp_st_s         next_s;

  logic            en;
  logic            pol;
  logic [2:0]      clock_prescale_select;
  logic [3:0]      mode;
  logic            rise;
  logic            fall;
  logic            act;
  logic            inact;
  logic            src;
  logic [6:0]      pmask;
  logic [ST_W-1:0] set;
  logic [ST_W-1:0] clr;
  logic            setup;
  logic            wr;
  logic            hit;
  logic            dual;

  tpp_db_if        dbp ();
  tpp_db_if        dbn ();

  assign en    = s.ctl1[BIT_ENABLE];
  assign pol   = s.ctl1[BIT_POLARITY];
  assign clock_prescale_select  = s.ctl1[CLOCK_PRESCALE_SELECT_MSB:CLOCK_PRESCALE_SELECT_LSB];
  assign mode  = {s.ctl0[BIT_MODE_HI], s.ctl1[MODE_LO_MSB:0]};
  assign dual  = en && (mode == M_DUALPWM);
  assign rise  = tin_i && !s.tin_q;
  assign fall  = !tin_i && s.tin_q;
  // polarity 0 picks the rising edge, 1 the falling edge
  assign act   = pol ? fall : rise;
  assign inact = pol ? rise : fall;
  assign pmask = 7'(pow2(clock_prescale_select) - 8'h01);

  assign setup = psel_i && !penable_i;
  assign wr    = psel_i && penable_i && pwrite_i;
  assign hit   = (paddr_i == OFS_CTL_ONE) || (paddr_i == OFS_CTL_ZERO) ||
                 (paddr_i == OFS_STATUS) || (paddr_i == OFS_CLEAR) ||
                 (paddr_i == OFS_IRQ_EN);

  //----------------------------------------------------------------------
  // prescaler source selection
  //----------------------------------------------------------------------
  always_comb begin
    case (mode)
      M_COUNTER, M_CMPCNT: src = act;
      M_GATED:             src = tin_i ^ pol;
      M_CAPCMP:            src = s.armed;
      default:             src = 1'b1;
    endcase
  end

  //----------------------------------------------------------------------
  // next state
  //----------------------------------------------------------------------
  always_comb begin
    next_s       = s;
    next_s.tin_q = tin_i;
    next_s.tick  = 1'b0;
    next_s.cap   = 1'b0;
    next_s.start = 1'b0;
    set          = '0;
    clr          = '0;

    if (!en) begin
      next_s.lvl   = pol;
      next_s.pcnt  = 7'h00;
      next_s.armed = 1'b0;
    end else begin
      // prescaler: one tick per 2**clock_prescale_select source events
      if (src) begin
        if ((s.pcnt & pmask) == pmask) begin
          next_s.tick = 1'b1;
          next_s.pcnt = 7'h00;
        end else begin
          next_s.pcnt = s.pcnt + 7'h01;
        end
      end

      // output level
      if (mode == M_ONESHOT) begin
        next_s.lvl = reload_i ? !pol : pol;
      end else if (toggles(mode)) begin
        if (reload_i) begin
          next_s.lvl = !s.lvl;
        end
      end else if (mode == M_PWM || mode == M_DUALPWM) begin
        // reload wins when both arrive together
        if (reload_i) begin
          next_s.lvl = pol;
        end else if (match_i) begin
          next_s.lvl = !pol;
        end
      end

      // input edge actions
      if (captures(mode) && act) begin
        next_s.cap = 1'b1;
      end
      if (mode == M_CAPCMP && act) begin
        if (s.armed) begin
          next_s.cap = 1'b1;
        end else begin
          next_s.armed = 1'b1;
        end
      end
      if (mode == M_TRIG && act) begin
        next_s.start = 1'b1;
      end
      if (mode == M_GATED && inact) begin
        set[ST_GATE] = 1'b1;
      end
      set[ST_RELOAD]  = reload_i;
      set[ST_CAPTURE] = next_s.cap;
    end

    // register writes land in the access phase
    if (wr) begin
      if (paddr_i == OFS_CTL_ONE) begin
        next_s.ctl1 = pwdata_i[7:0];
      end else if (paddr_i == OFS_CTL_ZERO) begin
        next_s.ctl0 = pwdata_i[3:0];
      end else if (paddr_i == OFS_CLEAR) begin
        clr = pwdata_i[ST_W-1:0];
      end else if (paddr_i == OFS_IRQ_EN) begin
        next_s.ien = pwdata_i[ST_W-1:0];
      end
    end
    // a new event beats a simultaneous clear
    next_s.stat = (s.stat & ~clr) | set;

    // read data captured in setup so the access phase needs no wait
    if (setup) begin
      next_s.err   = !hit;
      next_s.rdata = 32'h0000_0000;
      if (paddr_i == OFS_CTL_ONE) begin
        next_s.rdata = {24'h00_0000, s.ctl1};
      end else if (paddr_i == OFS_CTL_ZERO) begin
        next_s.rdata = {28'h000_0000, s.ctl0};
      end else if (paddr_i == OFS_STATUS) begin
        next_s.rdata = {29'h0000_0000, s.stat};
      end else if (paddr_i == OFS_IRQ_EN) begin
        next_s.rdata = {29'h0000_0000, s.ien};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s      <= '0;
      s.ctl1 <= RST_CTL_ONE;
      s.ctl0 <= RST_CTL_ZERO;
    end else begin
      s <= next_s;
    end
  end

  //----------------------------------------------------------------------
  // dead-band units and pin drive
  //----------------------------------------------------------------------
  assign dbp.raw = dual && s.lvl;
  assign dbn.raw = dual && !s.lvl;
  assign dbp.sel = s.ctl0[DB_MSB:0];
  assign dbn.sel = s.ctl0[DB_MSB:0];

  tpp_deadband u_db_p (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .db      (dbp.dly)
  );

  tpp_deadband u_db_n (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .db      (dbn.dly)
  );

  assign tout_o       = dual ? dbp.dly_out : s.lvl;
  assign tout_n_o     = dual ? dbn.dly_out : !s.lvl;
  assign enable_o     = en;
  assign mode_o       = mode;
  assign count_tick_o = s.tick;
  assign capture_o    = s.cap;
  assign start_o      = s.start;
  assign irq_o        = |(s.stat & s.ien);
  assign prdata_o     = s.rdata;
  assign pready_o     = 1'b1;
  assign pslverr_o    = psel_i && penable_i && s.err;

  //----------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  idle_level_a: assert property (
    (!en && $past(!en) && $stable(pol)) |-> tout_o == pol)
    else $error("disabled output differs from polarity");

  oneshot_pulse_a: assert property (
    (en && mode == M_ONESHOT && reload_i) |=> tout_o != $past(pol)
      ##1 ($past(en && mode == M_ONESHOT && !reload_i) -> tout_o == pol))
    else $error("one-shot pulse not one cycle");

  reload_toggle_a: assert property (
    (en && toggles(mode) && reload_i) |=> tout_o != $past(tout_o))
    else $error("output did not toggle on reload");

  count_edge_a: assert property (
    (en && mode == M_COUNTER && clock_prescale_select == 3'h0 && act) |=> count_tick_o)
    else $error("active input edge not counted");

  pwm_match_a: assert property (
    (en && mode == M_PWM && match_i && !reload_i) |=> tout_o == !pol)
    else $error("pwm match level wrong");

  capture_edge_a: assert property (
    (en && captures(mode) && act) |=> capture_o)
    else $error("capture missed on active edge");

  gate_event_a: assert property (
    (en && mode == M_GATED && inact) |=> s.stat[ST_GATE])
    else $error("gate inactive edge not flagged");

  capcmp_arm_a: assert property (
    (en && mode == M_CAPCMP && !s.armed && act) |=> s.armed && !capture_o)
    else $error("capture/compare start edge mishandled");

  dual_excl_a: assert property (
    dual |-> !(tout_o && tout_n_o))
    else $error("both pwm outputs high");

  trig_start_a: assert property (
    (en && mode == M_TRIG && act) |=> start_o)
    else $error("trigger edge did not start timer");

  prescale_div_a: assert property (
    (en && mode == M_CONT && clock_prescale_select == 3'h1 && count_tick_o && $stable(s.ctl1))
      |=> !count_tick_o)
    else $error("divide by two ticked twice in a row");

  prescale_clr_a: assert property (
    !en |=> s.pcnt == 7'h00)
    else $error("prescaler not cleared while disabled");

endmodule : tpp_top

// ---- tb/tpp_pin_model.sv ----
// partner model of the timer input pin and the output pair
module tpp_pin_model (
  // clock
  input  wire logic clk_i,
  // timer pins
  output logic      tin_o,
  input  wire logic tout_i,
  input  wire logic tout_n_i
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned out_moves;
  logic        last;

  initial tin_o = 1'b0;

  // level moves just after an edge, like any synchronous source
  task automatic set_tin(input logic v);
    @(posedge clk_i);
    tin_o <= v;
  endtask : set_tin

  always @(posedge clk_i) begin
    if (tout_i !== last) out_moves++;
    last = tout_i;
  end
endmodule : tpp_pin_model

// ---- tb/tpp_tb_top.sv ----
// self-checking bench for the timer polarity/prescaler block
module tpp_tb_top
  import tpp_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  //--------------------------------------------------
  // signals
  //--------------------------------------------------
  logic        clk_i, rst_b_i, psel_i, penable_i, pwrite_i;
  logic        reload_i, match_i, tin_i, tout_o, tout_n_o, e;
  logic        pready_o, pslverr_o, enable_o, irq_o;
  logic        count_tick_o, capture_o, start_o;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, d;
  logic [3:0]  mode_o;
  int          err_count, num_checks, n_tick, n_cap, n_start, n, t;
  int          lat [2];
  logic [3:0]  tog [9] = '{M_CONT, M_COUNTER, M_CAPTURE, M_COMPARE,
                           M_GATED, M_CAPCMP, M_CAPRST, M_CMPCNT, M_TRIG};

  tpp_top uut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .reload_i(reload_i), .match_i(match_i),
    .tin_i(tin_i), .tout_o(tout_o), .tout_n_o(tout_n_o),
    .enable_o(enable_o), .mode_o(mode_o), .count_tick_o(count_tick_o),
    .capture_o(capture_o), .start_o(start_o), .irq_o(irq_o)
  );

  tpp_pin_model pin (
    .clk_i(clk_i), .tin_o(tin_i), .tout_i(tout_o), .tout_n_i(tout_n_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // pulses are tallied mid-cycle, away from the edge that launches them
  always @(negedge clk_i) begin
    n_tick += count_tick_o;
    n_cap += capture_o;
    n_start += start_o;
  end

  //--------------------------------------------------
  // tasks
  //--------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic bail;
    err_count++;
    wrap_up();
  endtask : bail

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t reg %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t pin %h exp %h", $time, got, exp);
    end
  endtask : chk_pin

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int k;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    if (pready_o !== 1'b1) bail();
    d = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  // starts from disabled so every run begins from a cleared state
  task automatic cfg(input logic en, input logic p, input logic [2:0] pr,
                     input logic [3:0] m, input logic [2:0] db);
    apb(1'b1, OFS_CTL_ONE, 32'h0);
    apb(1'b1, OFS_CTL_ZERO, {28'h0, m[3], db});
    apb(1'b1, OFS_CTL_ONE, {24'h0, en, p, pr, m[2:0]});
    #1;
  endtask : cfg

  task automatic pulse(input logic is_match);
    @(posedge clk_i);
    if (is_match) match_i <= 1'b1;
    else reload_i <= 1'b1;
    @(posedge clk_i);
    match_i <= 1'b0;
    reload_i <= 1'b0;
    #1;
  endtask : pulse

  task automatic wait_hi(input logic use_n);
    n = 1;
    while ((use_n ? tout_n_o : tout_o) !== 1'b1) begin
      if (n > 300) bail();
      @(posedge clk_i);
      #1;
      n++;
    end
  endtask : wait_hi

  task automatic tin_step(input logic v, input logic [2:0] mask,
                          input logic [2:0] exp);
    int a, b, c;
    #1;
    a = n_tick;
    b = n_cap;
    c = n_start;
    pin.set_tin(v);
    repeat (4) @(posedge clk_i);
    #1;
    chk_pin(16'({1'(n_tick - a), 1'(n_cap - b), 1'(n_start - c)} & mask),
            16'(exp));
  endtask : tin_step

  task automatic edge_pair(input logic [3:0] m, input logic p,
                           input logic [2:0] mask);
    cfg(1'b1, p, 3'h0, m, 3'h0);
    tin_step(1'b1, mask, p ? 3'h0 : mask);
    tin_step(1'b0, mask, p ? mask : 3'h0);
  endtask : edge_pair

  task automatic gate(input logic p);
    cfg(1'b1, p, 3'h0, M_GATED, 3'h0);
    apb(1'b1, OFS_CLEAR, 32'h7);
    for (int a = 0; a < 2; a++) begin
      pin.set_tin(1'(a == 0) ^ p);
      repeat (3) @(posedge clk_i);
      #1;
      t = n_tick;
      repeat (8) @(posedge clk_i);
      #1;
      chk_pin(16'(n_tick - t), (a != 0) ? 16'h0 : 16'h8);
    end
    apb(1'b0, OFS_STATUS, 32'h0);
    chk_reg(d & 32'h4, 32'h4);
    pin.set_tin(1'b0);
  endtask : gate

  //--------------------------------------------------
  // sequence
  //--------------------------------------------------
  initial begin
    {rst_b_i, psel_i, penable_i, pwrite_i, reload_i, match_i} = '0;
    paddr_i = '0;
    pwdata_i = '0;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk_pin(16'({tout_o, tout_n_o, pready_o, irq_o}), 16'h6);
    apb(1'b0, OFS_CTL_ONE, 32'h0);
    chk_reg(d, 32'(RST_CTL_ONE));
    apb(1'b1, OFS_CTL_ONE, 32'h5b);
    apb(1'b0, OFS_CTL_ONE, 32'h0);
    chk_reg(d, 32'h5b);
    chk_pin(16'(tout_o), 16'h1);
    apb(1'b1, OFS_CTL_ZERO, 32'hff);
    apb(1'b0, OFS_CTL_ZERO, 32'h0);
    chk_reg(d, 32'h0f);
    apb(1'b0, 8'h14, 32'h0);
    chk_reg({d[30:0], e}, 32'h1);
    apb(1'b1, OFS_IRQ_EN, 32'h1);
    foreach (tog[i]) begin
      cfg(1'b1, 1'b0, 3'h0, tog[i], 3'h0);
      chk_pin(16'({enable_o, mode_o}), 16'({1'b1, tog[i]}));
      t = tout_o;
      pulse(1'b0);
      chk_pin(16'(tout_o), 16'(t == 0));
      pulse(1'b0);
      chk_pin(16'(tout_o), 16'(t));
      chk_pin(16'(irq_o), 16'h1);
      apb(1'b1, OFS_CLEAR, 32'h7);
      #1;
      chk_pin(16'(irq_o), 16'h0);
    end
    apb(1'b1, OFS_IRQ_EN, 32'h0);
    pulse(1'b0);
    chk_pin(16'(irq_o), 16'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk_reg(d, 32'h1);
    cfg(1'b1, 1'b0, 3'h0, M_ONESHOT, 3'h0);
    pulse(1'b0);
    chk_pin(16'(tout_o), 16'h1);
    @(posedge clk_i);
    #1;
    chk_pin(16'(tout_o), 16'h0);
    cfg(1'b1, 1'b0, 3'h0, M_PWM, 3'h0);
    pulse(1'b1);
    chk_pin(16'(tout_o), 16'h1);
    pulse(1'b0);
    chk_pin(16'(tout_o), 16'h0);
    for (int p = 0; p < 2; p++) begin
      edge_pair(M_COUNTER, 1'(p), 3'h4);
      edge_pair(M_TRIG, 1'(p), 3'h1);
      edge_pair(M_CAPTURE, 1'(p), 3'h2);
      edge_pair(M_CAPRST, 1'(p), 3'h2);
      edge_pair(M_CMPCNT, 1'(p), 3'h2);
      gate(1'(p));
    end
    cfg(1'b1, 1'b0, 3'h0, M_CAPCMP, 3'h0);
    tin_step(1'b1, 3'h2, 3'h0);
    tin_step(1'b0, 3'h2, 3'h0);
    tin_step(1'b1, 3'h2, 3'h2);
    pin.set_tin(1'b0);
    for (int k = 0; k < 8; k++) begin
      cfg(1'b1, 1'b0, 3'(k), M_CONT, 3'h0);
      repeat (4) @(posedge clk_i);
      #1;
      t = n_tick;
      repeat (256) @(posedge clk_i);
      #1;
      chk_pin(16'(n_tick - t), 16'(256 >> k));
    end
    // a prescaler left running would shorten the second wait
    for (int r = 0; r < 2; r++) begin
      cfg(1'b1, 1'b0, 3'h7, M_CONT, 3'h0);
      t = n_tick;
      n = 0;
      while (n_tick == t) begin
        if (n > 300) bail();
        @(posedge clk_i);
        #1;
        n++;
      end
      lat[r] = n;
      repeat (50) @(posedge clk_i);
    end
    chk_pin(16'(lat[1]), 16'(lat[0]));
    for (int s = 0; s < 8; s++) begin
      cfg(1'b1, 1'b0, 3'h0, M_DUALPWM, 3'(s));
      repeat (140) @(posedge clk_i);
      pulse(1'b1);
      // the falling output comes from the dead-band flop, one cycle on
      @(posedge clk_i);
      #1;
      chk_pin(16'(tout_n_o), 16'h0);
      wait_hi(1'b0);
      chk_pin(16'(n), 16'((s != 0) ? (1 << s) + 1 : 1));
      pulse(1'b0);
      @(posedge clk_i);
      #1;
      chk_pin(16'(tout_o), 16'h0);
      wait_hi(1'b1);
      chk_pin(16'(n), 16'((s != 0) ? (1 << s) + 1 : 1));
    end
    chk_pin(16'(pin.out_moves != 0), 16'h1);
    wrap_up();
  end
endmodule : tpp_tb_top
